// file: hw/bpr_defines.svh
/*
 Byte values, field positions, reset values and register offsets
 for the boot parameter request handler. Included by bare name.
*/
`ifndef BPR_DEFINES_SVH
`define BPR_DEFINES_SVH

`define BPR_SOH       8'h01
`define BPR_ETX       8'h03
`define BPR_SOD       8'h81
`define BPR_CMD_REQ   8'h52
`define BPR_RES_OK    8'h52
`define BPR_RES_ERR   8'hD2
`define BPR_LEN_HIGH  8'h00
`define BPR_LEN_OK    8'h02
`define BPR_LEN_ERR   8'h0A
`define BPR_LEN_CMD   16'h0002
`define BPR_MAX_LEN   16'h0400
`define BPR_PARAMETER_IDENTIFIER_MIN  8'h01
`define BPR_PARAMETER_IDENTIFIER_MAX  8'h04
`define BPR_PARAMETER_IDENTIFIER_L1   8'h04
`define BPR_PARAMETER_VALUE_BYTE_ON   3'h7
`define BPR_FILL      32'h0FFFFFFF
`define BPR_OK_LAST   4'h6
`define BPR_ERR_LAST  4'hE
`define BPR_STS_PKT   8'hC1
`define BPR_STS_SUM   8'hC2
`define BPR_STS_ACC   8'hC3
`define BPR_STS_PARM  8'hC5
`define BPR_STS_NONE  8'h00

`define BPR_REG_CFG   4'h0
`define BPR_REG_STAT  4'h4
`define BPR_REG_MASK  4'h8
`define BPR_REG_INFO  4'hC
`define BPR_CFG_RST   4'hF
`define BPR_EV_OK     0
`define BPR_EV_ERR    1
`define BPR_EV_DROP   2
`define BPR_EV_N      3
`define BPR_RESP_OK   2'h0
`define BPR_RESP_ERR  2'h2

`endif

// file: hw/bpr_pkg.sv
/*
 Types shared by the boot parameter request handler modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bpr_pkg;

	typedef enum logic [2:0] {
		BPR_HUNT, BPR_LEN_H, BPR_LEN_L, BPR_BODY, BPR_SUM, BPR_END
	} bpr_rx_state_t;

	typedef struct packed {
		logic [15:0] len;
		logic [7:0]  cmd;
		logic [7:0]  parameter_identifier;
		logic        sum_ok;
		logic        etx_ok;
	} bpr_frame_t;

	typedef struct packed {
		logic       is_err;
		logic [7:0] sts;
		logic [7:0] parameter_value_byte;
	} bpr_tx_req_t;

endpackage

// file: hw/bpr_rx_frame.sv
/*
 Command packet collector: hunts for the header byte, gathers length,
 body, checksum and end byte, then reports the frame for one cycle.
 Assumes bytes arrive from a receiver on the same clock.
*/
`include "bpr_defines.svh"
module bpr_rx_frame
	import bpr_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_b,
	input  wire logic [7:0] i_byte,
	input  wire logic       i_valid,
	output logic            o_done,
	output bpr_frame_t      o_frame
);
	bpr_rx_state_t state;
	logic [15:0]   cnt;
	logic [7:0]    acc;

	wire [7:0]  next_acc = 8'(acc + i_byte);
	wire [15:0] len_now  = {o_frame.len[15:8], i_byte};

	// A wild length holds the collector until that many bytes pass
	always_ff @(posedge i_clk_sys) begin
		o_done <= 1'b0;
		if (!i_rst_b) begin
			state   <= BPR_HUNT;
			cnt     <= 16'h0000;
			acc     <= 8'h00;
			o_frame <= '0;
		end else if (i_valid) begin
			unique case (state)
			BPR_HUNT: if (i_byte == `BPR_SOH) begin
				o_frame <= '0;
				state   <= BPR_LEN_H;
			end
			BPR_LEN_H: begin
				o_frame.len[15:8] <= i_byte;
				acc               <= i_byte;
				state             <= BPR_LEN_L;
			end
			BPR_LEN_L: begin
				o_frame.len[7:0] <= i_byte;
				acc              <= next_acc;
				cnt              <= 16'h0000;
				state <= (len_now == 16'h0000) ? BPR_SUM : BPR_BODY;
			end
			BPR_BODY: begin
				if (cnt == 16'h0000) o_frame.cmd <= i_byte;
				if (cnt == 16'h0001) o_frame.parameter_identifier <= i_byte;
				acc <= next_acc;
				cnt <= 16'(cnt + 16'h0001);
				if (16'(cnt + 16'h0001) == o_frame.len) state <= BPR_SUM;
			end
			BPR_SUM: begin
				o_frame.sum_ok <= (next_acc == 8'h00);
				state          <= BPR_END;
			end
			BPR_END: begin
				o_frame.etx_ok <= (i_byte == `BPR_ETX);
				o_done         <= 1'b1;
				state          <= BPR_HUNT;
			end
			endcase
		end
	end
endmodule // bpr_rx_frame

// file: hw/bpr_tx_frame.sv
/*
 Response packet sender: emits a parameter data packet or an error
 packet byte by byte, adding the checksum on the way.
 Assumes the downstream transmitter takes a byte on valid and ready.
*/
`include "bpr_defines.svh"
module bpr_tx_frame
	import bpr_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_b,
	input  wire logic       i_start,
	input  bpr_tx_req_t     i_req,
	input  wire logic       i_ready,
	output logic            o_busy,
	output logic [7:0]      o_byte,
	output logic            o_valid
);
	bpr_tx_req_t req_q;
	logic [3:0]  idx;
	logic [7:0]  sum;
	logic [7:0]  next_byte;

	wire       fire     = o_valid && i_ready;
	wire [3:0] last     = req_q.is_err ? `BPR_ERR_LAST : `BPR_OK_LAST;
	wire [3:0] nidx     = 4'(idx + 4'h1);
	wire [7:0] next_sum = (idx == 4'h0) ? sum : 8'(sum + o_byte);
	wire [7:0] chk      = 8'(8'h00 - next_sum);

	always_comb begin
		next_byte = `BPR_ETX;
		if (!req_q.is_err) begin
			unique case (nidx)
			4'h1:    next_byte = `BPR_LEN_HIGH;
			4'h2:    next_byte = `BPR_LEN_OK;
			4'h3:    next_byte = `BPR_RES_OK;
			4'h4:    next_byte = req_q.parameter_value_byte;
			4'h5:    next_byte = chk;
			default: next_byte = `BPR_ETX;
			endcase
		end else begin
			unique case (nidx)
			4'h1:       next_byte = `BPR_LEN_HIGH;
			4'h2:       next_byte = `BPR_LEN_ERR;
			4'h3:       next_byte = `BPR_RES_ERR;
			4'h4:       next_byte = req_q.sts;
			4'h5, 4'h9: next_byte = 8'(`BPR_FILL >> 24);
			4'h6, 4'hA: next_byte = 8'(`BPR_FILL >> 16);
			4'h7, 4'hB: next_byte = 8'(`BPR_FILL >> 8);
			4'h8, 4'hC: next_byte = 8'(`BPR_FILL);
			4'hD:       next_byte = chk;
			default:    next_byte = `BPR_ETX;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_busy  <= 1'b0;
			o_valid <= 1'b0;
			o_byte  <= 8'h00;
			idx     <= 4'h0;
			sum     <= 8'h00;
			req_q   <= '0;
		end else if (i_start && !o_busy) begin
			o_busy  <= 1'b1;
			o_valid <= 1'b1;
			o_byte  <= `BPR_SOD;
			idx     <= 4'h0;
			sum     <= 8'h00;
			req_q   <= i_req;
		end else if (fire) begin
			if (idx == last) begin
				o_valid <= 1'b0;
				o_busy  <= 1'b0;
			end else begin
				idx    <= nidx;
				sum    <= next_sum;
				o_byte <= next_byte;
			end
		end
	end
endmodule // bpr_tx_frame

// file: hw/bpr_request_handler.sv
/*
 Boot parameter request handler: checks each received command packet,
 picks the highest-priority failure or the parameter value, and sends
 the answer, or drops the packet while an answer is still going out. Settings and events are reached over AXI4-Lite.
 Assumes receive and transmit byte streams on the system clock and a
 one-cycle pulse from the encrypted write path.
*/
`include "bpr_defines.svh"
module bpr_request_handler
	import bpr_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_b,
	input  wire logic [7:0]        i_rx_byte,
	input  wire logic              i_rx_valid,
	input  wire logic              i_tx_ready,
	input  wire logic              i_enc_write_done,
	output logic [7:0]             o_tx_byte,
	output logic                   o_tx_valid,
	output logic                   o_init_allowed,
	output logic                   o_rma_allowed,
	output logic                   o_irq,
	input  wire logic [ADDR_W-1:0] i_axi_awaddr,
	input  wire logic              i_axi_awvalid,
	output logic                   o_axi_awready,
	input  wire logic [31:0]       i_axi_wdata,
	input  wire logic [3:0]        i_axi_wstrb,
	input  wire logic              i_axi_wvalid,
	output logic                   o_axi_wready,
	output logic [1:0]             o_axi_bresp,
	output logic                   o_axi_bvalid,
	input  wire logic              i_axi_bready,
	input  wire logic [ADDR_W-1:0] i_axi_araddr,
	input  wire logic              i_axi_arvalid,
	output logic                   o_axi_arready,
	output logic [31:0]            o_axi_rdata,
	output logic [1:0]             o_axi_rresp,
	output logic                   o_axi_rvalid,
	input  wire logic              i_axi_rready
);
	logic              rx_done;
	bpr_frame_t        frame;
	logic              tx_busy;
	logic              start;
	bpr_tx_req_t       req;
	bpr_tx_req_t       next_req;
	logic [3:0]        cfg;
	logic [`BPR_EV_N-1:0] stat;
	logic [`BPR_EV_N-1:0] mask;
	logic [`BPR_EV_N-1:0] ev_set;
	logic              enc_flag;
	logic [7:0]        last_sts;
	logic              aw_have;
	logic              w_have;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;

	bpr_rx_frame u_rx (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_byte    (i_rx_byte),
		.i_valid   (i_rx_valid),
		.o_done    (rx_done),
		.o_frame   (frame)
	);

	bpr_tx_frame u_tx (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_start   (start),
		.i_req     (req),
		.i_ready   (i_tx_ready),
		.o_busy    (tx_busy),
		.o_byte    (o_tx_byte),
		.o_valid   (o_tx_valid)
	);

	// Frame checks, each named for the failure it detects
	wire e_end = !frame.etx_ok;
	wire e_sum = !frame.sum_ok;
	wire e_fmt = (frame.len == 16'h0000) ||
		(frame.len > `BPR_MAX_LEN);
	wire e_cmd = (frame.len != `BPR_LEN_CMD);
	wire e_id  = (frame.parameter_identifier < `BPR_PARAMETER_IDENTIFIER_MIN) ||
		(frame.parameter_identifier > `BPR_PARAMETER_IDENTIFIER_MAX);
	wire e_acc = (frame.parameter_identifier == `BPR_PARAMETER_IDENTIFIER_L1) && enc_flag;
	wire framing_bad = e_end || e_sum || e_fmt;
	wire any_err = framing_bad || e_cmd || e_id || e_acc;

	// Clean packets for other commands belong to other handlers
	wire take   = rx_done && (framing_bad || frame.cmd == `BPR_CMD_REQ);
	// Start waits one cycle for busy to rise, so two launches never meet
	wire launch = take && !tx_busy && !start;
	wire drop   = take && !launch;

	// Priority order of the failure report
	wire [7:0] sts_sel =
		e_end ? `BPR_STS_PKT :
		e_sum ? `BPR_STS_SUM :
		(e_fmt || e_cmd) ? `BPR_STS_PKT :
		e_id  ? `BPR_STS_PARM :
		e_acc ? `BPR_STS_ACC : `BPR_STS_NONE;

	// Level two key off also blocks initialization
	wire [3:0] eff = {cfg[3], cfg[2], cfg[1], cfg[0] & cfg[2]};
	wire [1:0] sel = 2'(frame.parameter_identifier[1:0] - 2'h1);
	wire [7:0] parameter_value_byte = {5'h00, {3{eff[sel]}}};

	assign next_req = '{is_err: any_err, sts: sts_sel, parameter_value_byte: parameter_value_byte};
	assign ev_set = {drop, launch && any_err, launch && !any_err};

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			start    <= 1'b0;
			req      <= '0;
			last_sts <= `BPR_STS_NONE;
		end else begin
			start <= launch;
			if (launch) begin
				req      <= next_req;
				last_sts <= sts_sel;
			end
		end
	end

	// Only a device reset clears the encrypted write mark
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) enc_flag <= 1'b0;
		else if (i_enc_write_done) enc_flag <= 1'b1;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_init_allowed <= 1'b0;
			o_rma_allowed  <= 1'b0;
		end else begin
			o_init_allowed <= eff[0];
			o_rma_allowed  <= cfg[2];
		end
	end

	// Register bus: write address and data may come in either order
	wire aw_fire = i_axi_awvalid && o_axi_awready;
	wire w_fire  = i_axi_wvalid && o_axi_wready;
	wire ar_fire = i_axi_arvalid && o_axi_arready;
	wire wr_do   = aw_have && w_have && !o_axi_bvalid;
	wire next_aw = !wr_do && (aw_fire || aw_have);
	wire next_w  = !wr_do && (w_fire || w_have);
	wire next_rv = ar_fire || (o_axi_rvalid && !i_axi_rready);

	wire wr_cfg  = wr_do && aw_addr == `BPR_REG_CFG && w_strb[0];
	wire wr_stat = wr_do && aw_addr == `BPR_REG_STAT && w_strb[0];
	wire wr_mask = wr_do && aw_addr == `BPR_REG_MASK && w_strb[0];
	wire wr_hit  = (aw_addr == `BPR_REG_CFG) ||
		(aw_addr == `BPR_REG_STAT) || (aw_addr == `BPR_REG_MASK) ||
		(aw_addr == `BPR_REG_INFO);
	wire rd_hit  = (i_axi_araddr == `BPR_REG_CFG) ||
		(i_axi_araddr == `BPR_REG_STAT) ||
		(i_axi_araddr == `BPR_REG_MASK) ||
		(i_axi_araddr == `BPR_REG_INFO);
	wire [`BPR_EV_N-1:0] clr = wr_stat ? w_data[`BPR_EV_N-1:0] : '0;

	wire [31:0] rd_data =
		(i_axi_araddr == `BPR_REG_CFG)  ? {28'h0000000, cfg} :
		(i_axi_araddr == `BPR_REG_STAT) ? {29'h0, stat} :
		(i_axi_araddr == `BPR_REG_MASK) ? {29'h0, mask} :
		(i_axi_araddr == `BPR_REG_INFO) ?
			{22'h0, tx_busy, enc_flag, last_sts} : 32'h00000000;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			o_axi_awready <= 1'b0;
			o_axi_wready  <= 1'b0;
			o_axi_bvalid  <= 1'b0;
			o_axi_bresp   <= `BPR_RESP_OK;
		end else begin
			aw_have       <= next_aw;
			w_have        <= next_w;
			o_axi_awready <= !next_aw;
			o_axi_wready  <= !next_w;
			if (aw_fire) aw_addr <= i_axi_awaddr;
			if (w_fire) begin
				w_data <= i_axi_wdata;
				w_strb <= i_axi_wstrb;
			end
			if (wr_do) begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp  <= wr_hit ? `BPR_RESP_OK : `BPR_RESP_ERR;
			end else if (i_axi_bready) begin
				o_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid  <= 1'b0;
			o_axi_rdata   <= 32'h00000000;
			o_axi_rresp   <= `BPR_RESP_OK;
		end else begin
			o_axi_arready <= !next_rv;
			o_axi_rvalid  <= next_rv;
			if (ar_fire) begin
				o_axi_rdata <= rd_data;
				o_axi_rresp <= rd_hit ? `BPR_RESP_OK : `BPR_RESP_ERR;
			end
		end
	end

	// Settings change only from the bus, never from a command
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			cfg  <= `BPR_CFG_RST;
			mask <= '0;
		end else begin
			if (wr_cfg) cfg <= w_data[3:0];
			if (wr_mask) mask <= w_data[`BPR_EV_N-1:0];
		end
	end

	// Sticky events: a set in the clearing cycle survives
	for (genvar g = 0; g < `BPR_EV_N; g++) begin : g_ev
		always_ff @(posedge i_clk_sys) begin
			if (!i_rst_b) stat[g] <= 1'b0;
			else stat[g] <= ev_set[g] || (stat[g] && !clr[g]);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) o_irq <= 1'b0;
		else o_irq <= |(stat & mask);
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	a_start_frame: assert property (
		start |-> $past(rx_done))
		else $error("answer started without a received packet");
	a_end_first: assert property (
		launch && e_end |=> start && req.is_err && req.sts == `BPR_STS_PKT)
		else $error("missing end byte not reported first");
	a_sum_next: assert property (
		launch && !e_end && e_sum |=> req.sts == `BPR_STS_SUM)
		else $error("checksum failure not reported");
	a_len_check: assert property (
		launch && !e_end && !e_sum && e_cmd |=> req.sts == `BPR_STS_PKT)
		else $error("length failure not reported");
	a_cfg_kept: assert property (
		$changed(cfg) |-> $past(wr_cfg))
		else $error("settings changed without a bus write");
	a_id_range: assert property (
		launch && !framing_bad && !e_cmd && e_id |=>
			req.is_err && req.sts == `BPR_STS_PARM)
		else $error("bad identifier not reported");
	a_lock_refuse: assert property (
		launch && enc_flag && !framing_bad && !e_cmd &&
			frame.parameter_identifier == `BPR_PARAMETER_IDENTIFIER_L1 |=>
			req.is_err && req.sts == `BPR_STS_ACC)
		else $error("level one request accepted after encrypted write");
	a_ok_header: assert property (
		start && !req.is_err |=> o_tx_valid && o_tx_byte == `BPR_SOD)
		else $error("data packet does not open with its start byte");
	a_value_form: assert property (
		start && !req.is_err |-> req.parameter_value_byte == 8'h00 ||
			req.parameter_value_byte == {5'h00, `BPR_PARAMETER_VALUE_BYTE_ON})
		else $error("parameter value badly formed");
	a_key_chain: assert property (
		!cfg[2] |=> !o_init_allowed && !o_rma_allowed)
		else $error("init allowed with level two key disabled");

	c_ok_answer: cover property (start && !req.is_err);
	c_err_answer: cover property (start && req.is_err);
	c_dropped: cover property (drop);
	c_irq_raised: cover property ($rose(o_irq));
endmodule // bpr_request_handler

// file: tb/bpr_host_model.sv
/*
 Host programming tool model: frames command packets onto the receive
 byte stream and takes response bytes, promptly or with stalls.
 Assumes the handler samples bytes on the rising edge of i_clk_sys.
*/
`include "bpr_defines.svh"
module bpr_host_model (
	input  wire logic i_clk_sys,
	input  wire logic i_slow,
	output logic [7:0] o_rx_byte,
	output logic       o_rx_valid,
	output logic       o_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q[$];
	logic [1:0] cnt;
	initial begin
		o_rx_byte = 8'h00;
		o_rx_valid = 1'b0;
		o_tx_ready = 1'b1;
		cnt = 2'h0;
	end
	// Body is command, identifier, then zero fill up to the length
	task automatic send(input logic [7:0] id, length_low_byte, fix, etx);
		logic [7:0] s;
		logic [7:0] b;
		s = length_low_byte;
		q.push_back(8'h5A);
		q.push_back(`BPR_SOH);
		q.push_back(8'h00);
		q.push_back(length_low_byte);
		for (int i = 0; i < length_low_byte; i++) begin
			b = (i == 0) ? `BPR_CMD_REQ : (i == 1) ? id : 8'h00;
			q.push_back(b);
			s += b;
		end
		q.push_back(-s ^ fix);
		q.push_back(etx);
	endtask
	// Idle bytes flip so a stale value never looks like a header
	always @(posedge i_clk_sys) begin
		if (q.size() > 0) begin
			o_rx_byte <= q.pop_front();
			o_rx_valid <= 1'b1;
		end else begin
			o_rx_byte <= ~o_rx_byte;
			o_rx_valid <= 1'b0;
		end
		cnt <= cnt + 2'h1;
		o_tx_ready <= !i_slow || cnt == 2'h0;
	end
endmodule // bpr_host_model

// file: tb/test_bpr_request_handler.sv
/*
 Self-checking bench for the boot parameter request handler.
 Assumes the host model drives the byte streams; AXI is driven here.
*/
`include "bpr_defines.svh"
module test_bpr_request_handler;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, enc = 0, slow = 0;
	logic [7:0] rx_byte, tx_byte;
	logic rx_valid, tx_ready, tx_valid, init_ok, rma_ok, irq;
	logic [4:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [7:0] eq[$];
	logic [33:0] rq[$];
	int err_count = 0, tests_run = 0, seed = 88420;
	always #4 clk = ~clk;
	bpr_host_model i_bpr_host_model (.i_clk_sys(clk), .i_slow(slow),
		.o_rx_byte(rx_byte), .o_rx_valid(rx_valid),
		.o_tx_ready(tx_ready));
	bpr_request_handler #(.ADDR_W(5)) i_bpr_request_handler (
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_rx_byte(rx_byte),
		.i_rx_valid(rx_valid), .i_tx_ready(tx_ready),
		.i_enc_write_done(enc), .o_tx_byte(tx_byte),
		.o_tx_valid(tx_valid), .o_init_allowed(init_ok),
		.o_rma_allowed(rma_ok), .o_irq(irq), .i_axi_awaddr(awaddr),
		.i_axi_awvalid(awvalid), .o_axi_awready(awready),
		.i_axi_wdata(wdata), .i_axi_wstrb(4'hF), .i_axi_wvalid(wvalid),
		.o_axi_wready(wready), .o_axi_bresp(bresp),
		.o_axi_bvalid(bvalid), .i_axi_bready(bready),
		.i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
		.o_axi_arready(arready), .o_axi_rdata(rdata),
		.o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
		.i_axi_rready(rready));
	task automatic cmp(input logic [33:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// The oldest note is matched against each result as it appears
	always @(posedge clk) begin
		if (tx_valid && tx_ready) cmp({26'h0, tx_byte}, {26'h0, eq.pop_front()});
		if (rvalid && rready) cmp({rresp, rdata}, rq.pop_front());
	end
	task automatic expect_bytes(input logic [7:0] body[$]);
		logic [7:0] s;
		s = 8'h00;
		eq.push_back(`BPR_SOD);
		foreach (body[i]) begin
			eq.push_back(body[i]);
			s += body[i];
		end
		eq.push_back(-s);
		eq.push_back(`BPR_ETX);
	endtask
	task automatic pkt(input logic [7:0] id, length_low_byte, fix, etx,
		input logic ok, input logic [7:0] v);
		int n;
		if (ok) expect_bytes('{8'h00, 8'h02, 8'h52, v});
		else expect_bytes('{8'h00, 8'h0A, 8'hD2, v, 8'h0F, 8'hFF, 8'hFF,
			8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF});
		i_bpr_host_model.send(id, length_low_byte, fix, etx);
		n = 0;
		while ((eq.size() > 0 || tx_valid) && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000) cmp(34'h0, 34'h1);
		repeat (4) @(posedge clk);
	endtask
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		cmp({32'h0, bresp}, {32'h0, r});
		@(posedge clk);
	endtask
	task automatic axi_rd(input logic [4:0] a, input logic [33:0] e);
		int n;
		rq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!(rvalid && rready) && n < 50);
		if (n >= 50) cmp(34'h0, 34'h1);
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		#400000;
		err_count++;
		test_done();
	end
	initial begin
		do_reset();
		axi_rd(5'h00, 34'h00000000F);
		for (int i = 1; i <= 4; i++) pkt(i, 2, 0, 3, 1, 8'h07);
		$display("test ids done");
		axi_rd(5'h04, 34'h000000001);
		axi_wr(5'h08, 32'h1, 2'h0);
		repeat (3) @(posedge clk);
		cmp({33'h0, irq}, 34'h1);
		axi_wr(5'h04, 32'h1, 2'h0);
		repeat (3) @(posedge clk);
		cmp({33'h0, irq}, 34'h0);
		$display("test irq done");
		axi_wr(5'h00, 32'hB, 2'h0);
		slow <= 1'b1;
		repeat (3) @(posedge clk);
		cmp({32'h0, init_ok, rma_ok}, 34'h0);
		pkt(1, 2, 0, 3, 1, 8'h00);
		pkt(2, 2, 0, 3, 1, 8'h07);
		pkt(3, 2, 0, 3, 1, 8'h00);
		$display("test disable done");
		pkt(2, 2, 8'h10, 8'h00, 0, `BPR_STS_PKT);
		pkt(2, 2, 8'h10, 3, 0, `BPR_STS_SUM);
		pkt(2, 0, 0, 3, 0, `BPR_STS_PKT);
		pkt(2, 3, 8'h01, 3, 0, `BPR_STS_SUM);
		pkt(2, 3, 0, 3, 0, `BPR_STS_PKT);
		pkt(2, 2, 0, 8'h04, 0, `BPR_STS_PKT);
		pkt(0, 2, 0, 3, 0, `BPR_STS_PARM);
		for (int i = 0; i < 3; i++)
			pkt($random(seed) | 8'h08, 2, 0, 3, 0, `BPR_STS_PARM);
		// Second packet ends while the first answer is still going out
		i_bpr_host_model.send(2, 2, 0, 3);
		pkt(2, 2, 0, 3, 1, 8'h07);
		axi_rd(5'h04, 34'h000000007);
		slow <= 1'b0;
		axi_rd(5'h00, 34'h00000000B);
		$display("test errors done");
		enc <= 1'b1;
		@(posedge clk);
		enc <= 1'b0;
		pkt(4, 2, 0, 3, 0, `BPR_STS_ACC);
		axi_rd(5'h0C, 34'h0000001C3);
		pkt(3, 2, 0, 3, 1, 8'h00);
		do_reset();
		pkt(4, 2, 0, 3, 1, 8'h07);
		axi_rd(5'h00, 34'h00000000F);
		axi_wr(5'h10, 32'h5, 2'h2);
		axi_rd(5'h10, 34'h200000000);
		$display("test reset done");
		test_done();
	end
endmodule // test_bpr_request_handler
